// File: hw/diag_status_pkg.sv
/*
  Shared constants and carrier types for the diagnostic status bytes of
  a two-channel analog input module.
  Assumes one module clock; record indices are the byte positions of the
  diagnostic record as the reading party addresses it.
*/
package diag_status_pkg;

  // ************************************************************
  // record geometry
  // ************************************************************
  localparam int NUM_CHANNELS = 2;
  localparam int DIAG_BITS = 8;

  // byte index of each status byte inside the diagnostic record
  localparam logic [7:0] IDX_SUMMARY = 8'h02;
  localparam logic [7:0] IDX_INFO = 8'h03;
  localparam logic [7:0] IDX_RESERVED_C = 8'h04;
  localparam logic [7:0] IDX_EXTENDED = 8'h05;
  localparam logic [7:0] IDX_KIND = 8'h06;
  localparam logic [7:0] IDX_BITS = 8'h07;

  // ************************************************************
  // field positions
  // ************************************************************
  localparam int SUM_FAIL_BIT = 0;
  localparam int SUM_INTERNAL_BIT = 1;
  localparam int SUM_EXTERNAL_BIT = 2;
  localparam int SUM_CHANNEL_BIT = 3;
  localparam int SUM_AUX_BIT = 4;
  localparam int SUM_PARAM_BIT = 7;
  localparam int INFO_CHINFO_BIT = 4;
  localparam int EXT_OVERFLOW_BIT = 3;
  localparam int EXT_COMM_BIT = 4;
  localparam int EXT_PI_LOST_BIT = 6;

  // ************************************************************
  // fixed contents
  // ************************************************************
  localparam logic [3:0] MODULE_CLASS_ANALOG = 4'h5;
  localparam logic [6:0] KIND_DIGITAL_IN = 7'h70;
  localparam logic [6:0] KIND_ANALOG_IN = 7'h71;
  localparam logic [6:0] KIND_DIGITAL_OUT = 7'h72;
  localparam logic [6:0] KIND_ANALOG_OUT = 7'h73;
  localparam logic [6:0] KIND_ANALOG_INOUT = 7'h74;
  localparam logic [6:0] KIND_COUNTER = 7'h76;
  localparam logic [7:0] DIAG_BITS_COUNT = 8'h08;
  localparam logic [7:0] BYTE_ZERO = 8'h00;

  // ************************************************************
  // carriers
  // ************************************************************
  typedef struct packed {
    logic strobe;
    logic [7:0] index;
  } read_req_type;

  typedef struct packed {
    logic valid;
    logic [7:0] data;
  } read_resp_type;

  // levels and pulses from the module's own detectors, same clock
  typedef struct packed {
    logic module_fail;
    logic internal_err;
    logic external_err;
    logic param_err;
    logic buffer_overflow;
    logic comm_err;
    logic pi_lost;
  } module_event_type;

endpackage : diag_status_pkg

// File: hw/channel_diag_tracker.sv
/*
  Incoming/outgoing diagnostic tracker for one channel.
  Assumes cause bits come from detectors on the same clock and that the
  reset is already synchronised to that clock.
*/
`timescale 1ns/10ps

module channel_diag_tracker
  import diag_status_pkg::*;
#(
  parameter int CAUSE_BITS = DIAG_BITS
) (
  // clock and reset
  input wire logic clk_i,
  input wire logic rst_n_i,
  // channel causes
  input wire logic [CAUSE_BITS-1:0] cause_i,
  // diagnostic state
  output logic active_o,
  output logic incoming_o,
  output logic outgoing_o
);

  typedef struct packed {
    logic active;
    logic incoming;
    logic outgoing;
  } tracker_state_type;

  tracker_state_type state;
  tracker_state_type next_state;
  logic any_cause;

  assign any_cause = |cause_i;

  always_comb begin
    next_state = state;
    next_state.active = any_cause;
    // new causes while already active raise no second incoming event
    next_state.incoming = any_cause && !state.active; // R13
    // outgoing follows as soon as every cause has gone
    next_state.outgoing = state.active && !any_cause; // R12
  end

  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      state <= '0;
    end else begin
      state <= next_state;
    end
  end

  assign active_o = state.active;
  assign incoming_o = state.incoming;
  assign outgoing_o = state.outgoing;

endmodule : channel_diag_tracker

// File: hw/analog_module_diag_status_bytes.sv
/*
  Read-only diagnostic status bytes of a two-channel analog input module:
  summary, module information, extended error, channel kind and the count
  of diagnostic bits per channel, plus per-channel incoming/outgoing events.
  Assumes the record reader and the event detectors share CLOCK_I; only the
  auxiliary supply monitor and RESETN_I are asynchronous pins.
*/
// Behaviour
// R01 - summary bit 0 shows module failure and bit 1 an internal error.
// R02 - summary bit 2 shows an external error and bit 3 an error on any channel.
// R03 - summary bit 4 is high while the auxiliary supply is missing.
// R04 - summary bit 7 shows a parameter error and bits 6 to 5 read zero.
// R05 - module info bits 3 to 0 hold the analog class pattern 0101b.
// R06 - module info bit 4 flags channel information present, bits 7 to 5 read zero.
// R07 - extended bit 3 flags a diagnostics buffer overflow, bits 2 to 0 read zero.
// R08 - extended bit 4 flags an internal communication error.
// R09 - extended bit 6 flags a lost process interrupt, bits 5 and 7 read zero.
// R10 - channel kind bits 6 to 0 carry the kind code, 71h for analog input.
// R11 - the diagnostic bits count byte reads 08h.
// R12 - the outgoing event follows by itself once a channel's cause is gone.
// R13 - events of a channel between its incoming and outgoing are not reported.
// R14 - reserved bits and unmapped bytes read zero and nothing can be written.
`timescale 1ns/10ps

module analog_module_diag_status_bytes
  import diag_status_pkg::*;
#(
  parameter int NCH = NUM_CHANNELS,
  parameter logic [6:0] CHANNEL_KIND = KIND_ANALOG_IN
) (
  // clock and reset
  input wire logic CLOCK_I,
  input wire logic RESETN_I,
  // diagnostic record read port
  input wire read_req_type READ_REQ_I,
  output read_resp_type READ_RESP_O,
  // detectors
  input wire module_event_type MODULE_EVENT_I,
  input wire logic AUX_SUPPLY_MISSING_I,
  input wire logic [NCH-1:0][DIAG_BITS-1:0] CHANNEL_CAUSE_I,
  // diagnostic events
  output logic [NCH-1:0] DIAG_ACTIVE_O,
  output logic [NCH-1:0] DIAG_INCOMING_O,
  output logic [NCH-1:0] DIAG_OUTGOING_O,
  output logic MODULE_DIAG_O
);

  // ************************************************************
  // reset release
  // ************************************************************
  logic reset_meta;
  logic rst_n;

  always_ff @(posedge CLOCK_I or negedge RESETN_I) begin
    if (!RESETN_I) begin
      reset_meta <= 1'b0;
      rst_n <= 1'b0;
    end else begin
      reset_meta <= 1'b1;
      rst_n <= reset_meta;
    end
  end

  // ************************************************************
  // channel trackers
  // ************************************************************
  logic [NCH-1:0] chan_active;
  logic [NCH-1:0] chan_incoming;
  logic [NCH-1:0] chan_outgoing;

  for (genvar c = 0; c < NCH; c++) begin : g_chan
    channel_diag_tracker #(
      .CAUSE_BITS(DIAG_BITS)
    ) u_tracker (
      .clk_i(CLOCK_I),
      .rst_n_i(rst_n),
      .cause_i(CHANNEL_CAUSE_I[c]),
      .active_o(chan_active[c]),
      .incoming_o(chan_incoming[c]),
      .outgoing_o(chan_outgoing[c])
    );
  end

  // ************************************************************
  // state
  // ************************************************************
  typedef struct packed {
    logic aux_meta;
    logic aux_sync;
    logic overflow;
    logic comm;
    logic pi_lost;
    read_resp_type resp;
    logic [NCH-1:0] active;
    logic [NCH-1:0] incoming;
    logic [NCH-1:0] outgoing;
    logic module_diag;
  } diag_state_type;

  diag_state_type state;
  diag_state_type next_state;

  // ************************************************************
  // byte decode
  // ************************************************************
  function automatic logic [7:0] read_byte(
    input logic [7:0] index,
    input diag_state_type s,
    input module_event_type ev,
    input logic any_active
  );
    logic [7:0] b;
    b = BYTE_ZERO;
    unique case (index)
      IDX_SUMMARY: begin
        b[SUM_FAIL_BIT] = ev.module_fail; // R01
        b[SUM_INTERNAL_BIT] = ev.internal_err; // R01
        b[SUM_EXTERNAL_BIT] = ev.external_err; // R02
        b[SUM_CHANNEL_BIT] = any_active; // R02
        b[SUM_AUX_BIT] = s.aux_sync; // R03
        b[SUM_PARAM_BIT] = ev.param_err; // R04
      end
      IDX_INFO: begin
        b[3:0] = MODULE_CLASS_ANALOG; // R05
        b[INFO_CHINFO_BIT] = 1'b1; // R06
      end
      IDX_EXTENDED: begin
        b[EXT_OVERFLOW_BIT] = s.overflow; // R07
        b[EXT_COMM_BIT] = s.comm; // R08
        b[EXT_PI_LOST_BIT] = s.pi_lost; // R09
      end
      IDX_KIND: begin
        b[6:0] = CHANNEL_KIND; // R10
      end
      IDX_BITS: begin
        b = DIAG_BITS_COUNT; // R11
      end
      // reserved byte and every unmapped index read as zero
      default: begin
        b = BYTE_ZERO; // R14
      end
    endcase
    return b;
  endfunction : read_byte

  // ************************************************************
  // next state
  // ************************************************************
  logic read_ext;

  always_comb begin
    next_state = state;
    next_state.aux_meta = AUX_SUPPLY_MISSING_I;
    next_state.aux_sync = state.aux_meta;
    read_ext = READ_REQ_I.strobe && (READ_REQ_I.index == IDX_EXTENDED);
    // sticky until read; an event in the clearing cycle survives the read
    next_state.overflow = (state.overflow && !read_ext) || MODULE_EVENT_I.buffer_overflow; // R07
    next_state.comm = (state.comm && !read_ext) || MODULE_EVENT_I.comm_err; // R08
    next_state.pi_lost = (state.pi_lost && !read_ext) || MODULE_EVENT_I.pi_lost; // R09
    next_state.resp.valid = READ_REQ_I.strobe;
    next_state.resp.data = READ_REQ_I.strobe ?
        read_byte(READ_REQ_I.index, state, MODULE_EVENT_I, |chan_active) : BYTE_ZERO;
    next_state.active = chan_active;
    next_state.incoming = chan_incoming; // R13
    next_state.outgoing = chan_outgoing; // R12
    next_state.module_diag = |chan_active;
  end

  always_ff @(posedge CLOCK_I or negedge rst_n) begin
    if (!rst_n) begin
      state <= '0;
    end else begin
      state <= next_state;
    end
  end

  assign READ_RESP_O = state.resp;
  assign DIAG_ACTIVE_O = state.active;
  assign DIAG_INCOMING_O = state.incoming;
  assign DIAG_OUTGOING_O = state.outgoing;
  assign MODULE_DIAG_O = state.module_diag;

  // ************************************************************
  // checks
  // ************************************************************
  default clocking cb @(posedge CLOCK_I);
  endclocking
  default disable iff (!rst_n);

  sequence rd_at(logic [7:0] idx);
    READ_REQ_I.strobe && READ_REQ_I.index == idx;
  endsequence

  chk_read_latency: assert property ( // R14
    READ_REQ_I.strobe |=> READ_RESP_O.valid ##1 !$past(READ_REQ_I.strobe) || READ_RESP_O.valid)
    else $error("read answer not one cycle after strobe");

  chk_summary_fail: assert property ( // R01
    rd_at(IDX_SUMMARY) |=> READ_RESP_O.data[SUM_FAIL_BIT] == $past(MODULE_EVENT_I.module_fail)
      && READ_RESP_O.data[SUM_INTERNAL_BIT] == $past(MODULE_EVENT_I.internal_err))
    else $error("summary failure bits wrong");

  chk_summary_chan: assert property ( // R02
    rd_at(IDX_SUMMARY) |=> READ_RESP_O.data[SUM_CHANNEL_BIT] == |$past(chan_active)
      && READ_RESP_O.data[SUM_EXTERNAL_BIT] == $past(MODULE_EVENT_I.external_err))
    else $error("summary channel or external bit wrong");

  chk_aux_sync: assert property ( // R03
    (AUX_SUPPLY_MISSING_I [*3]) ##0 rd_at(IDX_SUMMARY) |=> READ_RESP_O.data[SUM_AUX_BIT])
    else $error("aux supply missing not reported");

  chk_param_bits: assert property ( // R04
    rd_at(IDX_SUMMARY) |=> READ_RESP_O.data[SUM_PARAM_BIT] == $past(MODULE_EVENT_I.param_err)
      && READ_RESP_O.data[6:5] == 2'h0)
    else $error("parameter bit or reserved summary bits wrong");

  chk_info_byte: assert property ( // R05
    rd_at(IDX_INFO) |=> READ_RESP_O.data == {3'h0, 1'b1, MODULE_CLASS_ANALOG})
    else $error("module information byte wrong");

  chk_overflow_sticky: assert property ( // R07
    MODULE_EVENT_I.buffer_overflow ##1 !READ_REQ_I.strobe ##1 rd_at(IDX_EXTENDED) |=>
      READ_RESP_O.data[EXT_OVERFLOW_BIT] && READ_RESP_O.data[2:0] == 3'h0)
    else $error("buffer overflow not held until read");

  chk_comm_sticky: assert property ( // R08
    MODULE_EVENT_I.comm_err ##1 !READ_REQ_I.strobe ##1 rd_at(IDX_EXTENDED) |=>
      READ_RESP_O.data[EXT_COMM_BIT])
    else $error("communication error not held until read");

  chk_pi_lost_set_wins: assert property ( // R09
    rd_at(IDX_EXTENDED) ##0 MODULE_EVENT_I.pi_lost ##1 (!READ_REQ_I.strobe) [*2]
      ##1 rd_at(IDX_EXTENDED) |=>
      READ_RESP_O.data[EXT_PI_LOST_BIT] && !READ_RESP_O.data[7] && !READ_RESP_O.data[5])
    else $error("lost interrupt flag dropped by a concurrent read");

  chk_kind_byte: assert property ( // R10
    rd_at(IDX_KIND) |=> READ_RESP_O.data == {1'b0, CHANNEL_KIND})
    else $error("channel kind byte wrong");

  chk_bits_count: assert property ( // R11
    rd_at(IDX_BITS) |=> READ_RESP_O.data == DIAG_BITS_COUNT)
    else $error("diagnostic bits count wrong");

  chk_reserved_zero: assert property ( // R14
    READ_REQ_I.strobe && READ_REQ_I.index > IDX_BITS |=> READ_RESP_O.data == BYTE_ZERO)
    else $error("unmapped byte not zero");

  chk_idle_zero: assert property ( // R14
    !READ_REQ_I.strobe |=> !READ_RESP_O.valid && READ_RESP_O.data == BYTE_ZERO)
    else $error("answer not idle without a strobe");

  // a read of the extended byte clears each flag unless that flag's own event arrives in the same cycle
  chk_ext_clear: assert property ( // R07
    READ_REQ_I.strobe && READ_REQ_I.index == IDX_EXTENDED && !MODULE_EVENT_I.buffer_overflow
      && !MODULE_EVENT_I.comm_err && !MODULE_EVENT_I.pi_lost |=>
      !state.overflow && !state.comm && !state.pi_lost)
    else $error("extended flags not cleared by a read");

  chk_ext_reserved: assert property ( // R09
    rd_at(IDX_EXTENDED) |=> READ_RESP_O.data[2:0] == 3'h0 && !READ_RESP_O.data[5]
      && !READ_RESP_O.data[7])
    else $error("reserved extended bits not zero");

  chk_aux_clear: assert property ( // R03
    (!AUX_SUPPLY_MISSING_I) [*3] ##0 rd_at(IDX_SUMMARY) |=> !READ_RESP_O.data[SUM_AUX_BIT])
    else $error("aux supply reported missing while present");

  // the channel pipeline is two edges from cause to outputs
  chk_module_diag_set: assert property ( // R02
    |CHANNEL_CAUSE_I |-> ##2 MODULE_DIAG_O)
    else $error("module diagnostic flag missing with a channel cause");

  chk_module_diag_clear: assert property ( // R12
    !(|CHANNEL_CAUSE_I) |-> ##2 !MODULE_DIAG_O)
    else $error("module diagnostic flag left on after causes cleared");

  for (genvar c = 0; c < NCH; c++) begin : g_chk
    chk_going_auto: assert property ( // R12
      $fell(|CHANNEL_CAUSE_I[c]) |-> ##2 DIAG_OUTGOING_O[c] && !DIAG_ACTIVE_O[c])
      else $error("outgoing event missing after cause cleared");

    chk_no_reentry: assert property ( // R13
      DIAG_INCOMING_O[c] |-> !$past(DIAG_ACTIVE_O[c]) ##1 !DIAG_INCOMING_O[c])
      else $error("second incoming event inside an active window");

    chk_incoming_active: assert property ( // R13
      DIAG_INCOMING_O[c] |-> DIAG_ACTIVE_O[c])
      else $error("incoming event outside an active window");

    chk_active_follows: assert property ( // R13
      |CHANNEL_CAUSE_I[c] |-> ##2 DIAG_ACTIVE_O[c])
      else $error("channel not active two cycles after its cause");

    chk_outgoing_once: assert property ( // R12
      DIAG_OUTGOING_O[c] |-> $past(DIAG_ACTIVE_O[c]) && !DIAG_ACTIVE_O[c]
        ##1 !DIAG_OUTGOING_O[c])
      else $error("outgoing event without a preceding window");

    cov_window: cover property (
      DIAG_INCOMING_O[c] ##[1:20] DIAG_OUTGOING_O[c]);
  end

  cov_summary_read: cover property (rd_at(IDX_SUMMARY) ##1 READ_RESP_O.data != BYTE_ZERO);
  cov_ext_clear: cover property (
    MODULE_EVENT_I.comm_err ##1 !READ_REQ_I.strobe ##1 rd_at(IDX_EXTENDED) ##3 rd_at(IDX_EXTENDED));
  cov_both_active: cover property (&DIAG_ACTIVE_O);

endmodule : analog_module_diag_status_bytes

// File: tb/diag_record_reader.sv
/*
  Reader model of the diagnostic record: issues one byte read at a time.
  Assumes the block answers one cycle after the strobe edge, as the read port does.
*/
`timescale 1ns/10ps

module diag_record_reader
  import diag_status_pkg::*;
(
  // clock
  input wire logic clk_i,
  // record read port
  output read_req_type req_o,
  input wire read_resp_type resp_i
);
  // ************************************************************
  // read cycle
  // ************************************************************
  initial req_o = '{strobe: 1'b0, index: 8'hFF};

  task automatic read_byte(input logic [7:0] idx, output logic vld, output logic [7:0] data,
                           output read_resp_type after);
    @(posedge clk_i);
    req_o <= '{strobe: 1'b1, index: idx};
    @(posedge clk_i);
    // released index lines flip, so a stale index never reads back right
    req_o <= '{strobe: 1'b0, index: ~idx};
    #1;
    vld = resp_i.valid;
    data = resp_i.data;
    @(posedge clk_i);
    #1;
    after = resp_i;
  endtask : read_byte
endmodule : diag_record_reader

// File: tb/analog_module_diag_status_bytes_tb.sv
/*
  Self-checking bench of the diagnostic status bytes.
  Assumes the reader model above and the package constants of the design.
*/
`timescale 1ns/10ps

module analog_module_diag_status_bytes_tb;
  import diag_status_pkg::*;

  // ************************************************************
  // signals and model state
  // ************************************************************
  logic clk;
  logic rst_n;
  read_req_type read_req;
  read_resp_type read_resp;
  module_event_type mod_ev;
  logic aux_missing;
  logic [NUM_CHANNELS-1:0][DIAG_BITS-1:0] cause;
  logic [NUM_CHANNELS-1:0] diag_active, diag_incoming, diag_outgoing;
  logic module_diag;
  logic [NUM_CHANNELS-1:0] m_p1, m_active, m_in, m_out;
  logic [7:0] m_ext;
  logic [31:0] r;
  logic [7:0] idx;
  logic run_chk;
  int n_mismatch = 0;
  int check_count = 0;
  int cycles = 0;

  initial begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end

  analog_module_diag_status_bytes #(.NCH(NUM_CHANNELS), .CHANNEL_KIND(KIND_ANALOG_IN)) dut_u (
    .CLOCK_I(clk), .RESETN_I(rst_n), .READ_REQ_I(read_req), .READ_RESP_O(read_resp),
    .MODULE_EVENT_I(mod_ev), .AUX_SUPPLY_MISSING_I(aux_missing), .CHANNEL_CAUSE_I(cause),
    .DIAG_ACTIVE_O(diag_active), .DIAG_INCOMING_O(diag_incoming),
    .DIAG_OUTGOING_O(diag_outgoing), .MODULE_DIAG_O(module_diag));

  diag_record_reader rdr_u (.clk_i(clk), .req_o(read_req), .resp_i(read_resp));

  // ************************************************************
  // channel event model: cause sampled at k shows after edge k+1
  // ************************************************************
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      m_p1 <= '0;
      m_active <= '0;
      m_in <= '0;
      m_out <= '0;
    end else begin
      for (int c = 0; c < NUM_CHANNELS; c++) m_p1[c] <= |cause[c];
      m_active <= m_p1;
      m_in <= m_p1 & ~m_active;
      m_out <= ~m_p1 & m_active;
    end
  end

  // ************************************************************
  // compares and verdict
  // ************************************************************
  task automatic print_verdict;
    $display("checks %0d mismatches %0d", check_count, n_mismatch);
    if (n_mismatch == 0 && check_count > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask : print_verdict

  task automatic cmp_bits(input logic [NUM_CHANNELS-1:0] got, exp, input string what);
    check_count++;
    if (got !== exp) begin
      n_mismatch++;
      $display("Error at %0t: %s got %b expected %b", $time, what, got, exp);
    end
  endtask : cmp_bits

  task automatic cmp_byte(input logic vld, input logic [7:0] got, exp, input string what);
    check_count++;
    if (vld !== 1'b1 || got !== exp) begin
      n_mismatch++;
      $display("Error at %0t: %s got %h/%b expected %h", $time, what, got, vld, exp);
    end
  endtask : cmp_byte

  always @(negedge clk) begin
    if (run_chk) begin
      cmp_bits(diag_active, m_active, "active");
      cmp_bits(diag_incoming, m_in, "incoming");
      cmp_bits(diag_outgoing, m_out, "outgoing");
      cmp_bits(NUM_CHANNELS'(module_diag), NUM_CHANNELS'(|m_active), "module diag");
    end
  end

  always @(posedge clk) begin
    cycles <= cycles + 1;
    if (cycles == 6000) begin
      n_mismatch++;
      $display("Error at %0t: run did not finish", $time);
      print_verdict;
    end
  end

  // ************************************************************
  // stimulus helpers
  // ************************************************************
  task automatic rd(input logic [7:0] i, input logic [7:0] exp);
    logic v;
    logic [7:0] d;
    read_resp_type after;
    rdr_u.read_byte(i, v, d, after);
    cmp_byte(v, d, exp, "read data");
    cmp_byte(~after.valid, after.data, BYTE_ZERO, "idle answer");
    if (i === IDX_EXTENDED) m_ext = BYTE_ZERO;
  endtask : rd

  task automatic pulse_ext(input logic [2:0] mask);
    @(posedge clk);
    mod_ev.buffer_overflow <= mask[0];
    mod_ev.comm_err <= mask[1];
    mod_ev.pi_lost <= mask[2];
    @(posedge clk);
    mod_ev.buffer_overflow <= 1'b0;
    mod_ev.comm_err <= 1'b0;
    mod_ev.pi_lost <= 1'b0;
    m_ext = m_ext | {1'b0, mask[2], 1'b0, mask[1], mask[0], 3'b000};
  endtask : pulse_ext

  function automatic logic [7:0] exp_sum();
    return {mod_ev.param_err, 2'b00, aux_missing, |m_active, mod_ev.external_err,
            mod_ev.internal_err, mod_ev.module_fail};
  endfunction : exp_sum

  // ************************************************************
  // main sequence
  // ************************************************************
  initial begin
    rst_n = 1'b0;
    mod_ev = '0;
    aux_missing = 1'b0;
    cause = '0;
    run_chk = 1'b0;
    m_ext = '0;
    void'($urandom(32'hEB35F612));
    repeat (16) @(posedge clk);
    rst_n <= 1'b1;
    repeat (3) @(posedge clk);
    run_chk = 1'b1;
    rd(IDX_INFO, {3'b000, 1'b1, MODULE_CLASS_ANALOG});
    rd(IDX_KIND, {1'b0, KIND_ANALOG_IN});
    rd(IDX_BITS, DIAG_BITS_COUNT);
    rd(IDX_RESERVED_C, BYTE_ZERO);
    rd(IDX_EXTENDED, BYTE_ZERO);
    rd(IDX_SUMMARY, BYTE_ZERO);
    repeat (20) begin
      idx = 8'($urandom);
      if (!(idx inside {[8'h02:8'h07]})) rd(idx, BYTE_ZERO);
    end
    // levels held for five cycles so the aux synchroniser has settled
    for (int i = 0; i < 40; i++) begin
      r = $urandom;
      @(posedge clk);
      mod_ev.module_fail <= r[0];
      mod_ev.internal_err <= r[1];
      mod_ev.external_err <= r[2];
      mod_ev.param_err <= r[3];
      aux_missing <= r[4];
      cause[r[5]] <= r[6] ? 8'(1 << r[9:7]) : 8'h00;
      repeat (5) @(posedge clk);
      rd(IDX_SUMMARY, exp_sum());
    end
    // causes change while active, and single-cycle causes
    for (int i = 0; i < 60; i++) begin
      r = $urandom;
      @(posedge clk);
      cause[0] <= (r[1:0] == 2'b00) ? 8'h00 : r[15:8];
      cause[1] <= (r[3:2] == 2'b00) ? 8'h00 : r[23:16];
      repeat (r[5:4]) @(posedge clk);
    end
    for (int m = 1; m < 8; m++) begin
      pulse_ext(3'(m));
      pulse_ext(3'(m >> 1));
      rd(IDX_EXTENDED, m_ext);
      rd(IDX_EXTENDED, BYTE_ZERO);
    end
    // a lost interrupt in the cycle of a clearing read survives that read
    fork
      rd(IDX_EXTENDED, BYTE_ZERO);
      pulse_ext(3'b100);
    join
    rd(IDX_EXTENDED, 8'(1 << EXT_PI_LOST_BIT));
    // second reset with flags set and causes active
    pulse_ext(3'b111);
    @(posedge clk);
    rst_n <= 1'b0;
    cause <= '0;
    mod_ev <= '0;
    aux_missing <= 1'b0;
    m_ext = '0;
    repeat (3) @(posedge clk);
    rst_n <= 1'b1;
    repeat (3) @(posedge clk);
    rd(IDX_EXTENDED, BYTE_ZERO);
    rd(IDX_SUMMARY, BYTE_ZERO);
    rd(IDX_BITS, DIAG_BITS_COUNT);
    print_verdict;
  end
endmodule : analog_module_diag_status_bytes_tb
